// ### pid_pin_irq.sv
// Pin interrupt detector: dedicated and port one pin interrupts, APB slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module pid_pin_irq
    import pid_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PID_AW-1:0] paddr,
    input wire logic [PID_DW-1:0] pwdata,
    output logic [PID_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_pin_in,
    input wire logic osc_pin_out,
    input wire logic [PID_NPINS-1:0] port_one_pin,
    input wire logic ext_irq_a_ack,
    input wire logic ext_irq_b_ack,
    output logic ext_irq_a_req,
    output logic ext_irq_b_req,
    output logic gp_irq_req
);

    typedef struct packed {
        logic [1:0] age;
        logic [1:0] osc_s1;
        logic [1:0] osc_s2;
        logic [1:0] osc_prev;
        logic [PID_NPINS-1:0] p1_s1;
        logic [PID_NPINS-1:0] p1_s2;
        logic [PID_NPINS-1:0] p1_prev;
        pid_cfg_s cfg;
        logic trig_a;
        logic trig_b;
        logic flag_a;
        logic flag_b;
        pid_clksrc_e clksrc;
        logic [PID_NPINS-1:0] flags;
        pid_apb_rsp_s rsp;
        pid_irq_s irq;
    } pid_state_s;

    function automatic logic reg_hit(input logic [PID_AW-1:0] a, input logic [7:0] idx);
        reg_hit = (a == {2'h0, idx, 2'h0});
    endfunction

    // Per pin: level seen twice, or a change towards the selected level
    function automatic logic [PID_NPINS-1:0] gp_detect(
        input logic [PID_NPINS-1:0] cur,
        input logic [PID_NPINS-1:0] prev,
        input pid_cfg_s cfg
    );
        logic [PID_NPINS-1:0] lvl;
        logic [PID_NPINS-1:0] edg;
        lvl = ~(cur ^ cfg.pol) & ~(prev ^ cfg.pol);
        edg = (cur ^ prev) & ~(cur ^ cfg.pol);
        gp_detect = ((~cfg.mode & lvl) | (cfg.mode & edg)) & cfg.en;
    endfunction

    pid_state_s s_q;
    pid_state_s s_d;

    logic cur_a;
    logic prev_a;
    logic cur_b;
    logic prev_b;
    logic set_a;
    logic set_b;
    logic [PID_NPINS-1:0] gp_set;
    logic acc_wr;
    logic hit;
    logic [7:0] rd;
    logic [7:0] ctrl_rd;

    // Routing of the oscillator pins by clock source; unrouted inputs idle high
    always_comb begin
        cur_a = 1'b1;
        prev_a = 1'b1;
        cur_b = 1'b1;
        prev_b = 1'b1;
        if (s_q.clksrc == PID_CLK_RC) begin
            cur_a = s_q.osc_s2[0];
            prev_a = s_q.osc_prev[0];
        end
        if (s_q.clksrc == PID_CLK_RC || s_q.clksrc == PID_CLK_EXT) begin
            cur_b = s_q.osc_s2[1];
            prev_b = s_q.osc_prev[1];
        end
    end

    // Falling transition between two successive samples
    assign set_a = s_q.trig_a & prev_a & ~cur_a;
    assign set_b = s_q.trig_b & prev_b & ~cur_b;
    assign gp_set = gp_detect(s_q.p1_s2, s_q.p1_prev, s_q.cfg);

    assign acc_wr = psel & penable & s_q.rsp.pready & pwrite;

    always_comb begin
        ctrl_rd = PID_RST_BYTE;
        ctrl_rd[PID_TC_IT_A] = s_q.trig_a;
        ctrl_rd[PID_TC_IE_A] = s_q.flag_a;
        ctrl_rd[PID_TC_IT_B] = s_q.trig_b;
        ctrl_rd[PID_TC_IE_B] = s_q.flag_b;
    end

    always_comb begin
        rd = PID_RST_BYTE;
        hit = 1'b1;
        if (reg_hit(paddr, PID_IDX_CTRL)) begin
            rd = ctrl_rd;
        end else if (reg_hit(paddr, PID_IDX_MODE)) begin
            rd = s_q.cfg.mode;
        end else if (reg_hit(paddr, PID_IDX_POL)) begin
            rd = s_q.cfg.pol;
        end else if (reg_hit(paddr, PID_IDX_EN)) begin
            rd = s_q.cfg.en;
        end else if (reg_hit(paddr, PID_IDX_FLAGS)) begin
            rd = s_q.flags;
        end else if (reg_hit(paddr, PID_IDX_CLKSRC)) begin
            rd = {6'h00, s_q.clksrc};
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.age = (s_q.age == 2'h3) ? s_q.age : s_q.age + 2'h1;

        // Two-flop synchronisers, then one more sample for comparisons
        s_d.osc_s1 = {osc_pin_out, osc_pin_in};
        s_d.osc_s2 = s_q.osc_s1;
        s_d.osc_prev = s_q.osc_s2;
        s_d.p1_s1 = port_one_pin;
        s_d.p1_s2 = s_q.p1_s1;
        s_d.p1_prev = s_q.p1_s2;

        // One wait state: data are ready with pready, writes land after it
        s_d.rsp.pready = psel & penable & ~s_q.rsp.pready;
        s_d.rsp.pslverr = s_d.rsp.pready & ~hit;
        s_d.rsp.prdata = {PID_DW{1'b0}};
        if (s_d.rsp.pready && !pwrite) begin
            s_d.rsp.prdata = {24'h000000, rd};
        end

        if (acc_wr && reg_hit(paddr, PID_IDX_CTRL)) begin
            s_d.trig_a = pwdata[PID_TC_IT_A];
            s_d.trig_b = pwdata[PID_TC_IT_B];
            s_d.flag_a = pwdata[PID_TC_IE_A];
            s_d.flag_b = pwdata[PID_TC_IE_B];
        end
        if (acc_wr && reg_hit(paddr, PID_IDX_MODE)) begin
            s_d.cfg.mode = pwdata[7:0];
        end
        if (acc_wr && reg_hit(paddr, PID_IDX_POL)) begin
            s_d.cfg.pol = pwdata[7:0];
        end
        if (acc_wr && reg_hit(paddr, PID_IDX_EN)) begin
            s_d.cfg.en = pwdata[7:0];
        end
        if (acc_wr && reg_hit(paddr, PID_IDX_CLKSRC)) begin
            s_d.clksrc = pid_clksrc_e'(pwdata[1:0]);
        end
        if (acc_wr && reg_hit(paddr, PID_IDX_FLAGS)) begin
            s_d.flags = pwdata[7:0];
        end

        // Acknowledge clears an edge flag, but a fresh edge wins
        if (ext_irq_a_ack) begin
            s_d.flag_a = 1'b0;
        end
        if (ext_irq_b_ack) begin
            s_d.flag_b = 1'b0;
        end
        if (set_a) begin
            s_d.flag_a = 1'b1;
        end
        if (set_b) begin
            s_d.flag_b = 1'b1;
        end
        // Level mode: flag mirrors the pin, so the source must hold it
        if (!s_d.trig_a) begin
            s_d.flag_a = ~cur_a;
        end
        if (!s_d.trig_b) begin
            s_d.flag_b = ~cur_b;
        end

        // Detection only ever sets flags
        s_d.flags = s_d.flags | gp_set;

        s_d.irq.a = s_d.flag_a;
        s_d.irq.b = s_d.flag_b;
        s_d.irq.gp = |s_d.flags;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            // Idle-high start, else level mode raises a false request after reset
            s_q.osc_s1 <= PID_RST_OSC;
            s_q.osc_s2 <= PID_RST_OSC;
            s_q.osc_prev <= PID_RST_OSC;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rsp.prdata;
    assign pready = s_q.rsp.pready;
    assign pslverr = s_q.rsp.pslverr;
    assign ext_irq_a_req = s_q.irq.a;
    assign ext_irq_b_req = s_q.irq.b;
    assign gp_irq_req = s_q.irq.gp;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_level_a_req: assert property (
        (s_q.clksrc == PID_CLK_RC && !s_q.trig_a && !s_q.osc_s2[0]
            && !(acc_wr && reg_hit(paddr, PID_IDX_CTRL)))
        |=> ext_irq_a_req)
        else $error("low level on pin a did not raise request");

    a_edge_a_set: assert property (
        (s_q.clksrc == PID_CLK_RC && s_q.trig_a && s_q.osc_prev[0] && !s_q.osc_s2[0]
            && !(acc_wr && reg_hit(paddr, PID_IDX_CTRL)))
        |=> s_q.flag_a && ext_irq_a_req)
        else $error("falling edge on pin a did not set flag");

    a_pin_sample_delay: assert property (
        (s_q.age == 2'h3) |-> (s_q.osc_s2[0] == $past(osc_pin_in, PID_HOLD_CYCLES)))
        else $error("dedicated pin sample not two edges behind pin");

    a_edge_ack_clear: assert property (
        (s_q.trig_a && ext_irq_a_ack && !set_a && !acc_wr) |=> !s_q.flag_a)
        else $error("acknowledge did not clear edge flag");

    a_xtal_no_pins: assert property (
        (s_q.clksrc == PID_CLK_XTAL) |-> (!set_a && !set_b && cur_a && cur_b))
        else $error("pin routed while crystal selected");

    a_gp_sets_flag: assert property (
        (gp_set != 8'h00) |=> ((s_q.flags & $past(gp_set)) == $past(gp_set)))
        else $error("detected pin condition did not set flag");

    a_gp_level_twice: assert property (
        (s_q.cfg.mode[0] == 1'b0 && s_q.cfg.en[0]
            && (s_q.p1_s2[0] != s_q.p1_prev[0])) |-> !gp_set[0])
        else $error("level seen once raised detection");

    a_gp_disabled: assert property (
        !(acc_wr && reg_hit(paddr, PID_IDX_FLAGS))
        |=> ((s_q.flags & ~$past(s_q.flags) & ~$past(s_q.cfg.en)) == 8'h00))
        else $error("disabled pin set its flag");

    a_gp_no_hw_clear: assert property (
        !(acc_wr && reg_hit(paddr, PID_IDX_FLAGS))
        |=> ((~s_q.flags & $past(s_q.flags)) == 8'h00))
        else $error("port flag cleared without software");

    a_gp_request: assert property (
        gp_irq_req == (s_q.flags != 8'h00))
        else $error("pin request does not follow flags");

    // Pin b checks mirror those of pin a, mixed with pin a release, edge-only and routing checks
    a_level_b_req: assert property (
        ((s_q.clksrc == PID_CLK_RC || s_q.clksrc == PID_CLK_EXT) && !s_q.trig_b
            && !s_q.osc_s2[1] && !(acc_wr && reg_hit(paddr, PID_IDX_CTRL)))
        |=> ext_irq_b_req)
        else $error("low level on pin b did not raise request");

    a_level_a_release: assert property (
        (s_q.clksrc == PID_CLK_RC && !s_q.trig_a && s_q.osc_s2[0]
            && !(acc_wr && reg_hit(paddr, PID_IDX_CTRL)))
        |=> !ext_irq_a_req)
        else $error("high level on pin a kept request");

    a_level_b_release: assert property (
        ((s_q.clksrc == PID_CLK_RC || s_q.clksrc == PID_CLK_EXT) && !s_q.trig_b
            && s_q.osc_s2[1] && !(acc_wr && reg_hit(paddr, PID_IDX_CTRL)))
        |=> !ext_irq_b_req)
        else $error("high level on pin b kept request");

    a_edge_b_set: assert property (
        ((s_q.clksrc == PID_CLK_RC || s_q.clksrc == PID_CLK_EXT) && s_q.trig_b
            && s_q.osc_prev[1] && !s_q.osc_s2[1]
            && !(acc_wr && reg_hit(paddr, PID_IDX_CTRL)))
        |=> s_q.flag_b && ext_irq_b_req)
        else $error("falling edge on pin b did not set flag");

    a_edge_only_fall: assert property (
        (s_q.trig_a && !s_q.flag_a && !set_a && !acc_wr) |=> !s_q.flag_a)
        else $error("edge flag a set without a falling edge");

    a_ack_clears_b: assert property (
        (s_q.trig_b && ext_irq_b_ack && !set_b && !acc_wr) |=> !ext_irq_b_req)
        else $error("acknowledge did not clear edge flag b");

    a_pin_a_unrouted: assert property (
        (s_q.clksrc != PID_CLK_RC) |-> (!set_a && cur_a))
        else $error("pin a routed without the RC clock source");

    // Bit 0 stands for all eight identical detectors
    a_gp_edge_hit: assert property (
        (s_q.cfg.mode[0] && s_q.cfg.en[0] && (s_q.p1_s2[0] != s_q.p1_prev[0])
            && (s_q.p1_s2[0] == s_q.cfg.pol[0])) |-> gp_set[0])
        else $error("edge in the selected direction not detected");

    a_gp_edge_still: assert property (
        (s_q.cfg.mode[0] && (s_q.p1_s2[0] == s_q.p1_prev[0])) |-> !gp_set[0])
        else $error("edge detection fired without a change");

    a_gp_level_hit: assert property (
        (!s_q.cfg.mode[0] && s_q.cfg.en[0] && (s_q.p1_s2[0] == s_q.cfg.pol[0])
            && (s_q.p1_prev[0] == s_q.cfg.pol[0])) |-> gp_set[0])
        else $error("level held two samples not detected");

    // Every access ends after exactly one wait state
    a_apb_one_wait: assert property (
        (psel && penable && !pready) |=> pready)
        else $error("access phase did not end after one wait state");

endmodule

// ### pid_pkg.sv
// Package: constants and carrier types for the pin interrupt detector
package pid_pkg;

    localparam int PID_NPINS = 8;
    localparam int PID_AW = 12;
    localparam int PID_DW = 32;

    // Clock period and the least hold time of a dedicated pin level
    localparam int PID_CLK_NS = 50;
    localparam int PID_HOLD_PERIODS = 2;
    localparam int PID_HOLD_CYCLES = PID_HOLD_PERIODS;

    // Register indices; byte address is four times the index
    localparam logic [7:0] PID_IDX_CTRL = 8'h88;
    localparam logic [7:0] PID_IDX_MODE = 8'h9A;
    localparam logic [7:0] PID_IDX_POL = 8'h9B;
    localparam logic [7:0] PID_IDX_EN = 8'h9C;
    localparam logic [7:0] PID_IDX_FLAGS = 8'h9D;
    localparam logic [7:0] PID_IDX_CLKSRC = 8'hA0;

    // Bit positions in timer_and_irq_control_reg
    localparam int PID_TC_IT_A = 0;
    localparam int PID_TC_IE_A = 1;
    localparam int PID_TC_IT_B = 2;
    localparam int PID_TC_IE_B = 3;

    localparam logic [7:0] PID_RST_BYTE = 8'h00;
    localparam logic [1:0] PID_RST_AGE = 2'h0;
    // Oscillator pin samplers start at the idle high level
    localparam logic [1:0] PID_RST_OSC = 2'h3;

    typedef enum logic [1:0] {
        PID_CLK_RC = 2'h0,
        PID_CLK_EXT = 2'h1,
        PID_CLK_XTAL = 2'h2
    } pid_clksrc_e;

    typedef struct packed {
        logic [PID_NPINS-1:0] mode;
        logic [PID_NPINS-1:0] pol;
        logic [PID_NPINS-1:0] en;
    } pid_cfg_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [PID_DW-1:0] prdata;
    } pid_apb_rsp_s;

    typedef struct packed {
        logic a;
        logic b;
        logic gp;
    } pid_irq_s;

endpackage

// ### pid_src.sv
// Outside signal sources that drive the interrupt pins
`timescale 1ns/1ps
module pid_src (
    input wire logic pclk,
    output logic osc_pin_in,
    output logic osc_pin_out,
    output logic [7:0] port_one_pin
);
    initial begin
        osc_pin_in = 1'b1;
        osc_pin_out = 1'b1;
        port_one_pin = 8'hFF;
    end
    // Every level stands two cycles, else the sampler may miss it
    task automatic put(input logic a, input logic b, input logic [7:0] p);
        @(posedge pclk);
        osc_pin_in <= a;
        osc_pin_out <= b;
        port_one_pin <= p;
        repeat (2) @(posedge pclk);
    endtask
endmodule

// ### testbench.sv
// Self-checking bench for the pin interrupt detector
`timescale 1ns/1ps
module testbench;
    import pid_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PID_AW-1:0] paddr = '0;
    logic [PID_DW-1:0] pwdata = '0;
    logic [PID_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic osc_pin_in;
    logic osc_pin_out;
    logic [PID_NPINS-1:0] port_one_pin;
    logic ext_irq_a_ack = 1'b0;
    logic ext_irq_b_ack = 1'b0;
    logic ext_irq_a_req;
    logic ext_irq_b_req;
    logic gp_irq_req;
    logic [PID_DW-1:0] rd;
    logic er;
    logic [7:0] regs [3] = '{PID_IDX_MODE, PID_IDX_POL, PID_IDX_EN};
    integer err_total = 0;
    integer checked = 0;
    integer seed = 32'hf2cab95a;
    integer md, pl, en, ex, cur, nx, v, i, k;

    always #25 pclk = ~pclk;

    pid_pin_irq pid_pin_irq_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .osc_pin_in, .osc_pin_out, .port_one_pin,
        .ext_irq_a_ack, .ext_irq_b_ack, .ext_irq_a_req, .ext_irq_b_req, .gp_irq_req);
    pid_src pid_src_i (.pclk, .osc_pin_in, .osc_pin_out, .port_one_pin);

    task automatic results;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready; a dead slave is left to the watchdog
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdx(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
        chk(er, 32'h0);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 3; i++) rdx(regs[i], 32'h0);
        rdx(PID_IDX_FLAGS, 32'h0);
        rdx(PID_IDX_CTRL, 32'h0);
        for (i = 0; i < 3; i++) begin
            v = $random(seed) & 255;
            apb(1'b1, regs[i], v);
            chk(er, 32'h0);
            rdx(regs[i], v);
        end
        apb(1'b1, 8'h9E, 32'hFF);
        chk(er, 32'h1);
        apb(1'b0, 8'h9E, 32'h0);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        for (k = 0; k < 4; k++) begin
            md = $random(seed) & 255;
            pl = $random(seed) & 255;
            en = $random(seed) & 255;
            cur = $random(seed) & 255;
            pid_src_i.put(1'b1, 1'b1, cur);
            apb(1'b1, PID_IDX_MODE, md);
            apb(1'b1, PID_IDX_POL, pl);
            apb(1'b1, PID_IDX_EN, en);
            for (i = 0; i < 7; i++) begin
                if (i == 0 || i == 4) begin
                    apb(1'b1, PID_IDX_FLAGS, 32'h0);
                    repeat (5) @(posedge pclk);
                    ex = en & ~md & ~(cur ^ pl) & 255;
                end
                nx = $random(seed) & 255;
                ex = ex | (en & ~(nx ^ pl) & (~md | (cur ^ nx)) & 255);
                pid_src_i.put(1'b1, 1'b1, nx);
                cur = nx;
                repeat (3) @(posedge pclk);
                rdx(PID_IDX_FLAGS, ex);
                chk(gp_irq_req, ex != 0);
            end
        end
        apb(1'b1, PID_IDX_EN, 32'h0);
        for (k = 0; k < 4; k++) begin
            apb(1'b1, PID_IDX_CLKSRC, k);
            rdx(PID_IDX_CLKSRC, k);
            pid_src_i.put(1'b0, 1'b0, cur);
            repeat (3) @(posedge pclk);
            chk({ext_irq_a_req, ext_irq_b_req}, {k == 0, k < 2});
            pid_src_i.put(1'b1, 1'b1, cur);
            repeat (3) @(posedge pclk);
            chk({ext_irq_a_req, ext_irq_b_req}, 32'h0);
        end
        apb(1'b1, PID_IDX_CLKSRC, 32'h0);
        apb(1'b1, PID_IDX_CTRL, 32'h05);
        pid_src_i.put(1'b0, 1'b0, cur);
        repeat (2) @(posedge pclk);
        pid_src_i.put(1'b1, 1'b1, cur);
        chk({ext_irq_a_req, ext_irq_b_req}, 32'h3);
        @(posedge pclk);
        ext_irq_a_ack <= 1'b1;
        @(posedge pclk);
        ext_irq_a_ack <= 1'b0;
        @(posedge pclk);
        chk({ext_irq_a_req, ext_irq_b_req}, 32'h1);
        ext_irq_b_ack <= 1'b1;
        @(posedge pclk);
        ext_irq_b_ack <= 1'b0;
        @(posedge pclk);
        chk({ext_irq_a_req, ext_irq_b_req}, 32'h0);
        rdx(PID_IDX_CTRL, 32'h05);
        results();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        results();
    end
endmodule
